//--- osc_far_side.sv
// Configuration store and oscillator pin model facing the selector
`timescale 1ns/10ps
`default_nettype none
module osc_far_side (
  input wire logic [2:0] i_source,
  input wire logic [8:0] i_mode,
  output logic [7:0] o_config_word,
  output logic o_one_family
);
  // Upper bits set to the nonzero pattern 5'h15 so a decoder that reads them is caught
  assign o_config_word = {5'h15, i_source};
  // Pins can serve only one family at a time
  assign o_one_family = $onehot({i_mode[8], i_mode[5], i_mode[4], i_mode[3]});
endmodule
`default_nettype wire

//--- osc_select_pkg.sv
// Package with register map, source encodings and carrier types for the clock source selector
package osc_select_pkg;
  localparam logic [11:0] trim_offset = 12'h000;
  localparam logic [11:0] config_offset = 12'h004;
  localparam logic [11:0] mode_offset = 12'h008;
  localparam int trim_width = 6;
  localparam int source_lsb = 0;
  localparam int source_width = 3;
  localparam logic [7:0] trim_reset = 8'h00;
  localparam logic [trim_width-1:0] trim_max = 6'h1f;
  localparam logic [trim_width-1:0] trim_min = 6'h20;

  typedef enum logic [2:0] {
    low_power_crystal_mode = 3'h0,
    standard_crystal_mode = 3'h1,
    high_speed_crystal_mode = 3'h2,
    external_rc_mode = 3'h3,
    internal_oscillator = 3'h4,
    ext_clock_low_power = 3'h5,
    ext_clock_medium_power = 3'h6,
    ext_clock_high_power = 3'h7
  } clock_source_sel_t;

  typedef enum logic [1:0] {
    st_load = 2'h0,
    st_run = 2'h1
  } cfg_state_t;

  // Decoded view of what the oscillator front end must do; only the family bits are one-hot
  typedef struct packed {
    logic ext_clock;
    logic [1:0] ext_power;
    logic int_osc;
    logic rc_osc;
    logic crystal;
    logic [1:0] crystal_drive;
    logic clock_input_pin_is_gpio;
  } osc_ctrl_t;

  typedef struct packed {
    cfg_state_t state;
    clock_source_sel_t source;
    logic [trim_width-1:0] trim;
    osc_ctrl_t ctrl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } osc_state_t;
endpackage

//--- osc_source_select.sv
// Clock source selector with internal oscillator trim register on APB
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module osc_source_select (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_first_configuration_word,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_ext_clock,
  output logic [1:0] o_ext_power,
  output logic o_internal_oscillator,
  output logic o_external_rc_mode,
  output logic o_crystal,
  output logic [1:0] o_crystal_drive,
  output logic o_clock_input_pin_is_gpio,
  output logic [5:0] o_freq_trim_field
);
  osc_select_pkg::osc_state_t state_reg;
  osc_select_pkg::osc_state_t state_next;
  // Config word is static but comes from fuse logic outside this clock
  logic [2:0] cfg_sync1_reg;
  logic [2:0] cfg_sync2_reg;
  logic [1:0] settle_reg;
  logic apb_access;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_sync1_reg <= 3'h0;
      cfg_sync2_reg <= 3'h0;
      settle_reg <= 2'h0;
    end else begin
      cfg_sync1_reg <= i_first_configuration_word[osc_select_pkg::source_lsb +: osc_select_pkg::source_width];
      cfg_sync2_reg <= cfg_sync1_reg;
      if (settle_reg != 2'h3) begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  assign apb_access = i_psel && i_penable && !state_reg.pready;

  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    case (state_reg.state)
      osc_select_pkg::st_load: begin
        // Latched once after the synchroniser has settled; no run-time change
        if (settle_reg == 2'h3) begin
          state_next.source = osc_select_pkg::clock_source_sel_t'(cfg_sync2_reg);
          state_next.state = osc_select_pkg::st_run;
        end
      end
      osc_select_pkg::st_run: begin
      end
      default: begin
        state_next.state = osc_select_pkg::st_load;
      end
    endcase

    state_next.ctrl = '0;
    case (state_next.source)
      osc_select_pkg::ext_clock_high_power: begin
        state_next.ctrl.ext_clock = 1'b1;
        state_next.ctrl.ext_power = 2'h2;
      end
      osc_select_pkg::ext_clock_medium_power: begin
        state_next.ctrl.ext_clock = 1'b1;
        state_next.ctrl.ext_power = 2'h1;
      end
      osc_select_pkg::ext_clock_low_power: begin
        state_next.ctrl.ext_clock = 1'b1;
        state_next.ctrl.ext_power = 2'h0;
      end
      osc_select_pkg::internal_oscillator: begin
        state_next.ctrl.int_osc = 1'b1;
        state_next.ctrl.clock_input_pin_is_gpio = 1'b1;
      end
      osc_select_pkg::external_rc_mode: begin
        state_next.ctrl.rc_osc = 1'b1;
      end
      osc_select_pkg::high_speed_crystal_mode: begin
        state_next.ctrl.crystal = 1'b1;
        state_next.ctrl.crystal_drive = 2'h2;
      end
      osc_select_pkg::standard_crystal_mode: begin
        state_next.ctrl.crystal = 1'b1;
        state_next.ctrl.crystal_drive = 2'h1;
      end
      osc_select_pkg::low_power_crystal_mode: begin
        state_next.ctrl.crystal = 1'b1;
        state_next.ctrl.crystal_drive = 2'h0;
      end
      default: begin
        state_next.ctrl = '0;
      end
    endcase
    // Front end stays idle until the source is latched; no early mode glitch
    if (state_next.state != osc_select_pkg::st_run) begin
      state_next.ctrl = '0;
    end

    // One wait state: registered pready rises on the second access cycle
    if (apb_access) begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h0000_0000;
      case (i_paddr)
        osc_select_pkg::trim_offset: begin
          if (i_pwrite) begin
            state_next.trim = i_pwdata[osc_select_pkg::trim_width-1:0];
          end else begin
            state_next.prdata = {26'h0, state_reg.trim};
          end
        end
        osc_select_pkg::config_offset: begin
          state_next.prdata = {29'h0, state_reg.source};
          state_next.pslverr = i_pwrite;
        end
        osc_select_pkg::mode_offset: begin
          state_next.prdata = {23'h0, state_reg.ctrl};
          state_next.pslverr = i_pwrite;
        end
        default: begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_prdata = state_reg.prdata;
  assign o_pready = state_reg.pready;
  assign o_pslverr = state_reg.pslverr;
  assign o_ext_clock = state_reg.ctrl.ext_clock;
  assign o_ext_power = state_reg.ctrl.ext_power;
  assign o_internal_oscillator = state_reg.ctrl.int_osc;
  assign o_external_rc_mode = state_reg.ctrl.rc_osc;
  assign o_crystal = state_reg.ctrl.crystal;
  assign o_crystal_drive = state_reg.ctrl.crystal_drive;
  assign o_clock_input_pin_is_gpio = state_reg.ctrl.clock_input_pin_is_gpio;
  assign o_freq_trim_field = state_reg.trim;

  sequence s_trim_write;
    i_psel && i_penable && i_pwrite && !o_pready && i_paddr == osc_select_pkg::trim_offset;
  endsequence

  a_trim_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_trim_write |=> o_freq_trim_field == $past(i_pwdata[5:0]))
    else $error("trim write not stored");
  a_trim_read_zero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_pready && $past(i_paddr) == osc_select_pkg::trim_offset |-> o_prdata[31:6] == 26'h0)
    else $error("trim upper bits not zero");
  a_trim_reset_zero: assert property (@(posedge i_core_clk)
    $rose(i_arst_n) |-> o_freq_trim_field == 6'h00)
    else $error("trim not cleared by reset");
  a_source_frozen: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run |=> $stable(state_reg.source))
    else $error("source changed at run time");
  a_source_loads: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> ##[1:8] state_reg.state == osc_select_pkg::st_run)
    else $error("source never loaded");
  a_ext_high_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.source == osc_select_pkg::ext_clock_high_power |-> o_ext_clock && o_ext_power == 2'h2)
    else $error("high power external clock wrong");
  a_ext_medium_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.source == osc_select_pkg::ext_clock_medium_power |-> o_ext_clock && o_ext_power == 2'h1)
    else $error("medium power external clock wrong");
  a_ext_low_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.source == osc_select_pkg::ext_clock_low_power |-> o_ext_clock && o_ext_power == 2'h0)
    else $error("low power external clock wrong");
  a_internal_oscillator_gpio_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_clock_input_pin_is_gpio |-> o_internal_oscillator && !o_ext_clock && !o_crystal && !o_external_rc_mode)
    else $error("internal oscillator select wrong");
  a_rc_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_external_rc_mode |-> state_reg.source == osc_select_pkg::external_rc_mode && !o_clock_input_pin_is_gpio)
    else $error("rc mode select wrong");
  a_hs_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_crystal && o_crystal_drive == 2'h2 |-> state_reg.source == osc_select_pkg::high_speed_crystal_mode)
    else $error("high speed crystal wrong");
  a_xt_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_crystal && o_crystal_drive == 2'h1 |-> state_reg.source == osc_select_pkg::standard_crystal_mode)
    else $error("standard crystal wrong");
  a_lp_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_crystal && o_crystal_drive == 2'h0 |-> state_reg.source == osc_select_pkg::low_power_crystal_mode)
    else $error("low power crystal wrong");

  // Bus side: every access phase is answered on the following edge
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence

  sequence s_trim_read;
    i_psel && i_penable && !i_pwrite && !o_pready && i_paddr == osc_select_pkg::trim_offset;
  endsequence

  sequence s_source_read;
    i_psel && i_penable && !i_pwrite && !o_pready && i_paddr == osc_select_pkg::config_offset;
  endsequence

  sequence s_cfg_write;
    i_psel && i_penable && i_pwrite && !o_pready && i_paddr == osc_select_pkg::config_offset;
  endsequence

  sequence s_mode_write;
    i_psel && i_penable && i_pwrite && !o_pready && i_paddr == osc_select_pkg::mode_offset;
  endsequence

  sequence s_unmapped;
    i_psel && i_penable && !o_pready && i_paddr != osc_select_pkg::trim_offset
      && i_paddr != osc_select_pkg::config_offset && i_paddr != osc_select_pkg::mode_offset;
  endsequence

  sequence s_cfg_settled;
    settle_reg == 2'h3 && state_reg.state == osc_select_pkg::st_load;
  endsequence

  a_access_answered: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_access |=> o_pready)
    else $error("access phase not answered");
  a_pready_pulse: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_pready |=> !o_pready)
    else $error("ready held over two cycles");
  a_error_with_ready: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_pslverr |-> o_pready)
    else $error("error flag without ready");
  a_trim_read_data: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_trim_read |=> !o_pslverr && o_prdata == {26'h0, $past(o_freq_trim_field)})
    else $error("trim read data wrong");
  a_trim_held: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !(i_psel && i_penable && i_pwrite && !o_pready && i_paddr == osc_select_pkg::trim_offset)
      |=> $stable(o_freq_trim_field))
    else $error("trim changed without a write");
  a_unmapped_refused: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_unmapped |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_cfg_write_refused: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_cfg_write |=> o_pready && o_pslverr)
    else $error("source register write not refused");
  a_mode_write_refused: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_mode_write |=> o_pready && o_pslverr)
    else $error("mode register write not refused");
  a_source_read: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_source_read |=> !o_pslverr && o_prdata == {29'h0, $past(state_reg.source)})
    else $error("source read data wrong");
  a_source_from_cfg: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_cfg_settled |=> state_reg.source == $past(cfg_sync2_reg))
    else $error("source not taken from configuration");
  a_source_one_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_cfg_settled |=> state_reg.state == osc_select_pkg::st_run)
    else $error("load state not left after settling");
  a_run_after_settle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run |-> settle_reg == 2'h3)
    else $error("run entered before synchroniser settled");
  a_ctrl_quiet_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_load |-> state_reg.ctrl == 9'h000)
    else $error("mode outputs active before source load");
  a_one_family: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run
      |-> $onehot({o_ext_clock, o_internal_oscillator, o_external_rc_mode, o_crystal}))
    else $error("more than one oscillator family active");
  a_gpio_with_internal_oscillator: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_internal_oscillator |-> o_clock_input_pin_is_gpio)
    else $error("input pin not released with internal oscillator");
  a_internal_oscillator_source: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run && state_reg.source == osc_select_pkg::internal_oscillator
      |-> o_internal_oscillator && o_clock_input_pin_is_gpio)
    else $error("internal oscillator not selected");
  a_ext_source_map: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_ext_clock |-> state_reg.source inside {osc_select_pkg::ext_clock_high_power,
      osc_select_pkg::ext_clock_medium_power, osc_select_pkg::ext_clock_low_power})
    else $error("external clock without external source");
  a_ext_power_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !o_ext_clock |-> o_ext_power == 2'h0)
    else $error("power range set without external clock");
  a_rc_source: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run && state_reg.source == osc_select_pkg::external_rc_mode
      |-> o_external_rc_mode && !o_crystal && !o_ext_clock)
    else $error("rc network not selected");
  a_hs_source: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run && state_reg.source == osc_select_pkg::high_speed_crystal_mode
      |-> o_crystal && o_crystal_drive == 2'h2)
    else $error("high speed crystal not driven");
  a_xt_source: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run && state_reg.source == osc_select_pkg::standard_crystal_mode
      |-> o_crystal && o_crystal_drive == 2'h1)
    else $error("standard crystal not driven");
  a_lp_source: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_reg.state == osc_select_pkg::st_run && state_reg.source == osc_select_pkg::low_power_crystal_mode
      |-> o_crystal && o_crystal_drive == 2'h0)
    else $error("low power crystal not driven");
  a_drive_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !o_crystal |-> o_crystal_drive == 2'h0)
    else $error("crystal drive set without crystal");
endmodule
`default_nettype wire

//--- tb_osc_source_select.sv
// Self-checking bench for the clock source selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_osc_source_select;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, one_family;
  logic [2:0] source = 3'h7;
  logic [7:0] cfg;
  logic ext_clock, int_osc, rc_mode, crystal, gpio;
  logic [1:0] ext_power, drive;
  logic [8:0] mode;
  assign mode = {ext_clock, ext_power, int_osc, rc_mode, crystal, drive, gpio};
  logic [5:0] trim;
  int mismatches = 0;
  int total_checks = 0;
  always #25 i_core_clk = ~i_core_clk;
  osc_source_select osc_source_select_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_first_configuration_word(cfg), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_ext_clock(ext_clock), .o_ext_power(ext_power), .o_internal_oscillator(int_osc),
    .o_external_rc_mode(rc_mode), .o_crystal(crystal), .o_crystal_drive(drive),
    .o_clock_input_pin_is_gpio(gpio), .o_freq_trim_field(trim));
  osc_far_side osc_far_side_i (.i_source(source), .i_mode(mode), .o_config_word(cfg),
    .o_one_family(one_family));
  function automatic logic [8:0] exp_mode(input logic [2:0] s);
    if (s >= 3'h5) exp_mode = {1'b1, s[1:0] - 2'h1, 6'h00};
    else if (s == 3'h4) exp_mode = 9'h021;
    else if (s == 3'h3) exp_mode = 9'h010;
    else exp_mode = {6'h01, s[1:0], 1'b0};
  endfunction
  // Request held until the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Read before this edge's updates land, so these are the sampled values
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) mismatches++;
  endtask
  // Source is latched only on the way out of reset
  task automatic do_reset(input logic [2:0] s, input int cyc);
    @(posedge i_core_clk);
    source <= s;
    i_arst_n <= 1'b0;
    repeat (cyc) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (6) @(posedge i_core_clk);
  endtask
  task automatic t_trim();
    apb(1'b1, 12'h000, 32'h0000001f);
    `CHK("trim wr err", 1'b0, err)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("trim max", 32'h0000001f, rd)
    `CHK("trim pin", osc_select_pkg::trim_max, trim)
    apb(1'b1, 12'h000, 32'hffffffea);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("trim upper", 32'h0000002a, rd)
    apb(1'b1, 12'h000, 32'h00000020);
    `CHK("trim min", osc_select_pkg::trim_min, trim)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 12'h004, 32'h00000003);
    `CHK("ro write err", 1'b1, err)
  endtask
  task automatic t_sources();
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s), 2);
      `CHK("mode", exp_mode(3'(s)), mode)
      `CHK("one family", 1'b1, one_family)
      `CHK("trim reset", 6'h00, trim)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("source reg", {29'h0, 3'(s)}, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("mode reg", {23'h0, exp_mode(3'(s))}, rd)
      apb(1'b1, 12'h000, 32'h00000015);
    end
    @(posedge i_core_clk);
    source <= 3'h0;
    repeat (6) @(posedge i_core_clk);
    `CHK("no rerun", exp_mode(3'h7), mode)
  endtask
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(3'h7, 20);
    t_trim();
    t_sources();
    conclude();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (4000) @(posedge i_core_clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
